/* File: src/p4pc_port.sv */
// Port four pins 0 to 2 with an AXI4-Lite register slave and interrupt.
// How it works
// - Data register writes set levels driven on pins configured as outputs.
// - Data reads return the live pin level for bits set to input.
// - Control bit 3 enables the pin as an interrupt source; reset off.
// - Pin 0 control bit 2 hands the pin to serial data out.
// - Pin 1 control bit 2 selects plain port or serial data-ready.
// - Pin 2 control bit 2 hands the pin to the serial clock.
// - Control bit 1 is direction: 0 input, 1 output; reset input.
// - In input mode bit 0 chooses resistor input (0) or high impedance.
// - In output mode bit 0 chooses push-pull (0) or open drain.
// - A shared control bit 2 chooses pull-up or pull-down for all pins.
// - Pin 1 alternate routes the serial data-ready output to the pin.
`default_nettype none
module p4pc_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  output logic [2:0] pin_pull_en,
  output logic [2:0] pin_pull_up,
  input wire logic serial_data_out,
  input wire logic serial_data_ready,
  input wire logic serial_clk_out,
  input wire logic serial_clk_oe,
  output logic serial_clk_in,
  output logic irq
);
  localparam int unsigned NP = p4pc_pkg::NUM_PINS;
  localparam int unsigned DW = p4pc_pkg::DATA_W;

  function automatic p4pc_pkg::p4pc_sel_t decode(input logic [7:0] addr);
    logic [p4pc_pkg::IDX_W-1:0] idx;
    idx = addr[7:2];
    if (addr[1:0] != 2'h0) begin
      decode = p4pc_pkg::P4PC_SEL_NONE;
    end else if (idx == p4pc_pkg::IDX_PORT_FOUR_DATA) begin
      decode = p4pc_pkg::P4PC_SEL_DATA;
    end else if (idx == p4pc_pkg::IDX_PIN0_CONTROL ||
                 idx == p4pc_pkg::IDX_PIN1_CONTROL ||
                 idx == p4pc_pkg::IDX_PIN2_CONTROL) begin
      decode = p4pc_pkg::P4PC_SEL_CTRL;
    end else if (idx == p4pc_pkg::IDX_PORT_SHARED_CONTROL) begin
      decode = p4pc_pkg::P4PC_SEL_SHARED;
    end else if (idx == p4pc_pkg::IDX_IRQ_STATUS) begin
      decode = p4pc_pkg::P4PC_SEL_STATUS;
    end else if (idx == p4pc_pkg::IDX_IRQ_ENABLE) begin
      decode = p4pc_pkg::P4PC_SEL_ENABLE;
    end else if (idx == p4pc_pkg::IDX_IRQ_CLEAR) begin
      decode = p4pc_pkg::P4PC_SEL_CLEAR;
    end else begin
      decode = p4pc_pkg::P4PC_SEL_NONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] awaddr_q;
  logic [DW-1:0] wdata_q;
  logic wstrb0_q;
  logic [DW-1:0] data_q;
  logic [3:0] ctrl_q [NP];
  logic pull_dir_q;
  logic [NP-1:0] irq_status_q;
  logic [NP-1:0] irq_en_q;
  logic [NP-1:0] pin_meta_q;
  logic [NP-1:0] pin_sync_q;
  logic [NP-1:0] pin_prev_q;
  logic [NP-1:0] dir_vec;
  logic [NP-1:0] ie_vec;
  logic [NP-1:0] pin_chg;
  logic [NP-1:0] irq_clear;
  logic wr_exec;
  p4pc_pkg::p4pc_sel_t wsel;
  p4pc_pkg::p4pc_sel_t rsel;
  logic [1:0] ctrl_widx;

  assign wr_exec = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wsel = decode(awaddr_q);
  assign rsel = decode(s_axi_araddr);
  assign ctrl_widx = 2'(awaddr_q[7:2] - p4pc_pkg::IDX_PIN0_CONTROL);
  assign pin_chg = pin_sync_q ^ pin_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Write channels: address and data are held until both are in.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= p4pc_pkg::RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 4'h0;
      wstrb0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata[DW-1:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_exec) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wsel == p4pc_pkg::P4PC_SEL_NONE ||
                        wsel == p4pc_pkg::P4PC_SEL_STATUS) ?
                       p4pc_pkg::RESP_SLVERR : p4pc_pkg::RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Register updates; a write without byte lane 0 changes nothing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_q <= p4pc_pkg::RST_DATA;
      pull_dir_q <= p4pc_pkg::RST_PULL_DIRECTION;
      irq_en_q <= p4pc_pkg::RST_IRQ;
      for (int i = 0; i < NP; i++) begin
        ctrl_q[i] <= p4pc_pkg::RST_CONTROL;
      end
    end else if (wr_exec && wstrb0_q) begin
      unique case (wsel)
        p4pc_pkg::P4PC_SEL_DATA: data_q <= wdata_q;
        p4pc_pkg::P4PC_SEL_CTRL: ctrl_q[ctrl_widx] <= wdata_q;
        p4pc_pkg::P4PC_SEL_SHARED:
          pull_dir_q <= wdata_q[p4pc_pkg::SHR_PULL_DIRECTION];
        p4pc_pkg::P4PC_SEL_ENABLE: irq_en_q <= wdata_q[NP-1:0];
        p4pc_pkg::P4PC_SEL_STATUS, p4pc_pkg::P4PC_SEL_CLEAR,
        p4pc_pkg::P4PC_SEL_NONE: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one read in flight, answered one edge after acceptance.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= p4pc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= p4pc_pkg::RESP_OKAY;
      unique case (rsel)
        p4pc_pkg::P4PC_SEL_DATA: begin
          // Input bits show the pin, output bits the stored value.
          s_axi_rdata[DW-1] <= data_q[DW-1];
          s_axi_rdata[NP-1:0] <= (pin_sync_q & ~dir_vec) |
                                 (data_q[NP-1:0] & dir_vec);
        end
        p4pc_pkg::P4PC_SEL_STATUS: s_axi_rdata[NP-1:0] <= irq_status_q;
        p4pc_pkg::P4PC_SEL_ENABLE: s_axi_rdata[NP-1:0] <= irq_en_q;
        // Control and clear registers are write-only and read as zero.
        p4pc_pkg::P4PC_SEL_CTRL, p4pc_pkg::P4PC_SEL_SHARED,
        p4pc_pkg::P4PC_SEL_CLEAR: begin
        end
        p4pc_pkg::P4PC_SEL_NONE: s_axi_rresp <= p4pc_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin levels cross in through two flip-flops; the third finds changes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
      pin_prev_q <= 3'h0;
      serial_clk_in <= 1'b0;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
      serial_clk_in <= pin_sync_q[2];
    end
  end

  // Either edge of an enabled pin is an event; a new event beats a clear.
  assign irq_clear = (wr_exec && wstrb0_q &&
                      wsel == p4pc_pkg::P4PC_SEL_CLEAR) ?
                     wdata_q[NP-1:0] : 3'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_q <= p4pc_pkg::RST_IRQ;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clear) | (pin_chg & ie_vec);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_q & irq_en_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [NP-1:0] alt_val;
  logic [NP-1:0] alt_oe;

  // Pins 0 and 1 always drive in their serial roles unless bit 0 selects open drain; the clock follows
  // the serial port's own direction.
  assign alt_val = {serial_clk_out, serial_data_ready, serial_data_out};
  assign alt_oe = {serial_clk_oe, 1'b1, 1'b1};

  for (genvar g = 0; g < NP; g++) begin : g_pin
    assign dir_vec[g] = ctrl_q[g][p4pc_pkg::CTL_DIRECTION];
    assign ie_vec[g] = ctrl_q[g][p4pc_pkg::CTL_IRQ_ENABLE];
    p4pc_pin_cell u_cell (
      .aclk(aclk),
      .aresetn(aresetn),
      .ctrl(ctrl_q[g]),
      .data_bit(data_q[g]),
      .alt_val(alt_val[g]),
      .alt_oe(alt_oe[g]),
      .pull_dir(pull_dir_q),
      .pin_out_q(pin_out[g]),
      .pin_oe_q(pin_oe[g]),
      .pin_pull_en_q(pin_pull_en[g]),
      .pin_pull_up_q(pin_pull_up[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_data_write;
    wr_exec && wstrb0_q && wsel == p4pc_pkg::P4PC_SEL_DATA;
  endsequence

  sequence s_data_read;
    s_axi_arvalid && s_axi_arready && rsel == p4pc_pkg::P4PC_SEL_DATA;
  endsequence

  a_data_store: assert property (
    s_data_write |=> data_q == $past(wdata_q) && s_axi_bvalid
  ) else $error("data write not stored");

  a_read_pin_level: assert property (
    s_data_read |=> s_axi_rvalid &&
      s_axi_rdata[NP-1:0] == $past((pin_sync_q & ~dir_vec) |
                                   (data_q[NP-1:0] & dir_vec))
  ) else $error("data read mixes pin and stored bits wrongly");

  a_irq_event_set: assert property (
    |(pin_chg & ie_vec) |=>
      (irq_status_q & $past(pin_chg & ie_vec)) == $past(pin_chg & ie_vec)
      ##1 irq == |($past(irq_status_q & irq_en_q))
  ) else $error("enabled pin change not latched");

  a_irq_masked_src: assert property (
    (irq_status_q[0] == 1'b0 && !ie_vec[0]) |=> !irq_status_q[0]
  ) else $error("disabled pin raised an event");

  a_push_pull_out: assert property (
    ctrl_q[0][2:0] == 3'h2 |=> pin_oe[0] && pin_out[0] == $past(data_q[0])
  ) else $error("push-pull drive wrong");

  a_open_drain_out: assert property (
    ctrl_q[1][2:0] == 3'h3 |=> !pin_out[1] && pin_oe[1] == !$past(data_q[1])
  ) else $error("open drain drive wrong");

  a_input_style: assert property (
    ctrl_q[2][2:1] == 2'h0 |=> !pin_oe[2] &&
      pin_pull_en[2] == !$past(ctrl_q[2][0])
  ) else $error("input style wrong");

  a_pull_select: assert property (
    $changed(pull_dir_q) |=> pin_pull_up == {NP{!$past(pull_dir_q)}}
  ) else $error("pull direction not applied");

  a_serial_out_alt: assert property (
    ctrl_q[0][2] && !ctrl_q[0][0] |=>
      pin_oe[0] && pin_out[0] == $past(serial_data_out)
  ) else $error("serial data out not routed");

  a_ready_alt: assert property (
    ctrl_q[1][2:1] == 2'h2 && !ctrl_q[1][0] |=>
      pin_oe[1] && pin_out[1] == $past(serial_data_ready)
  ) else $error("data ready not routed");

  a_clock_alt: assert property (
    ctrl_q[2][2] |=> pin_oe[2] == ($past(serial_clk_oe) &&
      ($past(!ctrl_q[2][0]) || !$past(serial_clk_out)))
  ) else $error("serial clock direction wrong");

  // A clear only loses against an event on the same bit in the same cycle.
  a_irq_clear: assert property (
    |irq_clear |=> (irq_status_q & $past(irq_clear & ~(pin_chg & ie_vec)))
      == '0
  ) else $error("cleared status bit stayed set");

  a_status_read: assert property (
    s_axi_arvalid && s_axi_arready && rsel == p4pc_pkg::P4PC_SEL_STATUS |=>
      s_axi_rdata[NP-1:0] == $past(irq_status_q)
  ) else $error("status read wrong");

  a_irq_quiet: assert property (
    !(|(irq_status_q & irq_en_q)) |=> !irq
  ) else $error("interrupt raised without an enabled event");

  a_pull_off_out: assert property (
    ctrl_q[0][2:1] == 2'h1 |=> !pin_pull_en[0]
  ) else $error("termination left on in output mode");

  a_clk_in_follow: assert property (
    serial_clk_in == $past(pin_sync_q[2])
  ) else $error("serial clock input not passed on");
endmodule // p4pc_port
`default_nettype wire

/* File: src/p4pc_pkg.sv */
// Shared constants for the port four pin control block.
`default_nettype none
package p4pc_pkg;
  localparam int unsigned NUM_PINS = 3;
  localparam int unsigned DATA_W = 4;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned IDX_W = 6;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_PORT_FOUR_DATA = 6'h02;
  localparam logic [IDX_W-1:0] IDX_PIN0_CONTROL = 6'h18;
  localparam logic [IDX_W-1:0] IDX_PIN1_CONTROL = 6'h19;
  localparam logic [IDX_W-1:0] IDX_PIN2_CONTROL = 6'h1a;
  localparam logic [IDX_W-1:0] IDX_PORT_SHARED_CONTROL = 6'h1c;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h20;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 6'h21;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 6'h22;

  // Pin control register fields.
  localparam int unsigned CTL_IRQ_ENABLE = 3;
  localparam int unsigned CTL_ALT_SELECT = 2;
  localparam int unsigned CTL_DIRECTION = 1;
  localparam int unsigned CTL_DRIVE_STYLE = 0;
  // Shared control register field.
  localparam int unsigned SHR_PULL_DIRECTION = 2;

  localparam logic [DATA_W-1:0] RST_DATA = 4'h0;
  localparam logic [DATA_W-1:0] RST_CONTROL = 4'h0;
  localparam logic RST_PULL_DIRECTION = 1'b0;
  localparam logic [NUM_PINS-1:0] RST_IRQ = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    P4PC_SEL_DATA,
    P4PC_SEL_CTRL,
    P4PC_SEL_SHARED,
    P4PC_SEL_STATUS,
    P4PC_SEL_ENABLE,
    P4PC_SEL_CLEAR,
    P4PC_SEL_NONE
  } p4pc_sel_t;
endpackage
`default_nettype wire

/* File: src/p4pc_pin_cell.sv */
// One port pin: selects port or serial use and forms drive, enable and pull.
`default_nettype none
module p4pc_pin_cell (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] ctrl,
  input wire logic data_bit,
  input wire logic alt_val,
  input wire logic alt_oe,
  input wire logic pull_dir,
  output logic pin_out_q,
  output logic pin_oe_q,
  output logic pin_pull_en_q,
  output logic pin_pull_up_q
);
  logic alt_sel;
  logic drive_en;
  logic value;
  logic open_drain;

  assign alt_sel = ctrl[p4pc_pkg::CTL_ALT_SELECT];
  // The serial signal owns value and direction while selected.
  assign drive_en = alt_sel ? alt_oe : ctrl[p4pc_pkg::CTL_DIRECTION];
  assign value = alt_sel ? alt_val : data_bit;
  assign open_drain = ctrl[p4pc_pkg::CTL_DRIVE_STYLE];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
      pin_pull_en_q <= 1'b0;
    end else if (drive_en) begin
      // Open drain only ever pulls low; a high is released to the pin.
      pin_out_q <= open_drain ? 1'b0 : value;
      pin_oe_q <= open_drain ? ~value : 1'b1;
      pin_pull_en_q <= 1'b0;
    end else begin
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
      pin_pull_en_q <= ~open_drain;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_pull_up_q <= 1'b1;
    end else begin
      pin_pull_up_q <= ~pull_dir;
    end
  end
endmodule // p4pc_pin_cell
`default_nettype wire

/* File: tb/p4pc_pins_model.sv */
// Partner model: the wiring and termination seen by port pins 0 to 2.
`default_nettype none
module p4pc_pins_model (
  input wire logic aclk,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic [2:0] pin_pull_en,
  input wire logic [2:0] pin_pull_up,
  input wire logic [2:0] ext_en,
  input wire logic [2:0] ext_val,
  output logic [2:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] last_q = 3'h0;
  always_ff @(posedge aclk) begin
    last_q <= pin_in;
  end
  // A pin that nobody drives or terminates flips every cycle, so a stale
  // level can never pass for a held one.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pin_pull_en[i]) begin
        pin_in[i] = pin_pull_up[i];
      end else begin
        pin_in[i] = ~last_q[i];
      end
    end
  end
endmodule // p4pc_pins_model
`default_nettype wire

/* File: tb/p4pc_port_test.sv */
// Self-checking bench for the port four pin control block.
`default_nettype none
module p4pc_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, serial_clk_oe, serial_clk_in, irq;
  logic [2:0] pin_in, pin_out, pin_oe, pin_pull_en, pin_pull_up;
  logic [2:0] alt_v, ext_en, ext_val;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  p4pc_port uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe,
    .pin_pull_en, .pin_pull_up, .serial_data_out(alt_v[0]),
    .serial_data_ready(alt_v[1]), .serial_clk_out(alt_v[2]),
    .serial_clk_oe, .serial_clk_in, .irq
  );
  p4pc_pins_model ext (
    .aclk, .pin_out, .pin_oe, .pin_pull_en, .pin_pull_up, .ext_en,
    .ext_val, .pin_in
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // The whole run needs well under a thousand cycles.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      test_done();
    end
  end

  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
        exp);
    end
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // One edge between transfers, so no strobe is set twice in a step.
    @(posedge aclk);
  endtask

  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic set_ctl(input logic [31:0] c0, c1, c2);
    wr(8'h60, c0);
    wr(8'h64, c1);
    wr(8'h68, c2);
    idle(4);
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check(pin_oe, 3'h0);
    check(pin_pull_en, 3'h7);
    check(pin_pull_up, 3'h7);
    check(irq, 1'b0);
    rdr(8'h08);
    check(rd, 32'h7);
    check(rsp, p4pc_pkg::RESP_OKAY);
    rdr(8'h0c);
    check(rsp, p4pc_pkg::RESP_SLVERR);
    $display("test reset done");
  endtask

  task automatic t_output;
    set_ctl(32'h2, 32'h2, 32'h2);
    wr(8'h08, 32'hb);
    idle(2);
    check(pin_oe, 3'h7);
    check(pin_out, 3'h3);
    rdr(8'h08);
    check(rd, 32'hb);
    set_ctl(32'h3, 32'h2, 32'h2);
    check(pin_oe, 3'h6);
    wr(8'h08, 32'ha);
    idle(2);
    check({pin_oe, pin_out}, 6'h3a);
    // A write without byte lane 0 is answered but leaves the data alone.
    s_axi_wstrb <= 4'h0;
    wr(8'h08, 32'h4);
    check(rsp, p4pc_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rdr(8'h08);
    check(rd, 32'ha);
    $display("test output done");
  endtask

  task automatic t_input;
    ext_en <= 3'h2;
    ext_val <= 3'h0;
    set_ctl(32'h2, 32'h1, 32'h0);
    wr(8'h08, 32'h1);
    idle(4);
    check(pin_pull_en, 3'h4);
    rdr(8'h08);
    check(rd, 32'h5);
    wr(8'h70, 32'h4);
    ext_val <= 3'h2;
    idle(4);
    check(pin_pull_up, 3'h0);
    rdr(8'h08);
    check(rd, 32'h3);
    wr(8'h70, 32'h0);
    idle(2);
    check(pin_pull_up, 3'h7);
    $display("test input done");
  endtask

  task automatic t_alt;
    ext_en <= 3'h0;
    wr(8'h08, 32'h5);
    serial_clk_oe <= 1'b1;
    set_ctl(32'h4, 32'h4, 32'h4);
    for (int v = 0; v < 2; v++) begin
      alt_v <= {3{v[0]}};
      idle(2);
      check(pin_oe, 3'h7);
      check(pin_out, {3{v[0]}});
    end
    serial_clk_oe <= 1'b0;
    ext_en <= 3'h4;
    ext_val <= 3'h0;
    idle(5);
    check(pin_oe[2], 1'b0);
    check(serial_clk_in, 1'b0);
    ext_val <= 3'h4;
    idle(5);
    check(serial_clk_in, 1'b1);
    $display("test alternate done");
  endtask

  task automatic t_irq;
    ext_en <= 3'h3;
    ext_val <= 3'h3;
    set_ctl(32'h8, 32'h0, 32'h0);
    wr(8'h84, 32'h1);
    wr(8'h88, 32'h7);
    idle(2);
    check(irq, 1'b0);
    ext_val <= 3'h2;
    idle(6);
    check(irq, 1'b1);
    rdr(8'h80);
    check(rd, 32'h1);
    wr(8'h84, 32'h0);
    idle(2);
    check(irq, 1'b0);
    wr(8'h88, 32'h1);
    rdr(8'h80);
    check(rd, 32'h0);
    wr(8'h84, 32'h3);
    ext_val <= 3'h0;
    idle(6);
    rdr(8'h80);
    check(rd, 32'h0);
    check(irq, 1'b0);
    wr(8'h80, 32'h1);
    check(rsp, p4pc_pkg::RESP_SLVERR);
    $display("test interrupt done");
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    alt_v = 3'h0;
    ext_en = 3'h0;
    ext_val = 3'h0;
    serial_clk_oe = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    idle(4);
    t_reset();
    t_output();
    t_input();
    t_alt();
    t_irq();
    test_done();
  end
endmodule // p4pc_port_test
`default_nettype wire
